// >>> hw/ssba_pkg.sv
// Package: constants, carriers and helpers of the serdes word aligner
package ssba_pkg;
    localparam int unsigned WORD_W       = 10;
    localparam int unsigned FIFO_DEPTH   = 4;
    localparam int unsigned MAX_CHAN     = 20;
    localparam int unsigned CTRL_W       = 23;
    // Bit rate is one bit per mclk cycle
    localparam int unsigned BIT_MBPS     = 100;
    localparam int unsigned HS_LIMIT_MBPS = 840;
    localparam int unsigned LS_LIMIT_MBPS = 462;
    localparam logic [7:0]  OFS_CTRL     = 8'h00;
    localparam logic [7:0]  OFS_STATUS   = 8'h04;
    localparam logic [7:0]  OFS_TXDATA   = 8'h08;
    localparam logic [7:0]  OFS_RXDATA   = 8'h0C;
    localparam logic [7:0]  OFS_SLIP     = 8'h10;
    localparam int unsigned ST_LOCKED    = 0;
    localparam int unsigned ST_RX_NEW    = 1;
    localparam int unsigned ST_RATE_OK   = 2;
    localparam int unsigned ST_CHAN_CLIP = 3;
    localparam int unsigned ST_TX_FULL   = 4;
    localparam int unsigned ST_SLIPS     = 8;
    localparam int unsigned RX_NEW_POS   = 16;
    localparam logic [22:0] CTRL_RST     = 23'h04200C;

    typedef enum logic [2:0] {JSEL_1, JSEL_2, JSEL_4, JSEL_7, JSEL_8, JSEL_10} ssba_jsel_t;
    typedef enum logic [1:0] {REF_PIN, REF_GLOBAL, REF_REGIONAL} ssba_ref_t;
    typedef enum logic [1:0] {FWD_OFF, FWD_FULL, FWD_DIV} ssba_fwd_t;

    typedef struct packed {
        logic [4:0] chan_cnt;
        logic       low_speed;
        logic       cross_quad;
        logic [3:0] fwd_div;
        ssba_fwd_t  fwd_mode;
        ssba_ref_t  ref_sel;
        logic [4:0] mult_m1;
        ssba_jsel_t jsel;
    } ssba_ctrl_t;

    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [7:0]  paddr;
        logic [31:0] pwdata;
    } ssba_apb_req_t;

    typedef struct packed {
        logic        pready;
        logic        pslverr;
        logic [31:0] prdata;
    } ssba_apb_rsp_t;

    typedef struct packed {
        logic              valid;
        logic [WORD_W-1:0] data;
    } ssba_word_t;

    function automatic logic [3:0] ssba_jwidth(input ssba_jsel_t j);
        logic [3:0] w;
        unique case (j)
            JSEL_1:  w = 4'h1;
            JSEL_2:  w = 4'h2;
            JSEL_4:  w = 4'h4;
            JSEL_7:  w = 4'h7;
            JSEL_8:  w = 4'h8;
            default: w = 4'hA;
        endcase
        return w;
    endfunction

    // Unsupported divisors fall back to half rate
    function automatic logic [3:0] ssba_fwd_divisor(input logic [3:0] d);
        logic [3:0] r;
        r = d;
        if (!(d == 4'h4 || d == 4'h7 || d == 4'h8 || d == 4'hA)) begin
            r = 4'h2;
        end
        return r;
    endfunction
endpackage

// >>> hw/ssba_fifo.sv
// Small valid/ready FIFO in front of the serializer
`timescale 1ns/1ns
module ssba_fifo #(
    parameter int unsigned WIDTH = 10,
    parameter int unsigned DEPTH = 4
) (
    input  wire logic             mclk,
    input  wire logic             rst_n,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    localparam int unsigned AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [WIDTH-1:0] mem_d [DEPTH];
    logic [AW:0]      wp_q, wp_d, rp_q, rp_d;
    logic             push, pop;

    always_comb begin
        in_ready  = (wp_q - rp_q) != (AW+1)'(DEPTH);
        out_valid = wp_q != rp_q;
        out_data  = mem_q[rp_q[AW-1:0]];
        push      = in_valid && in_ready;
        pop       = out_valid && out_ready;
        mem_d     = mem_q;
        if (push) begin
            mem_d[wp_q[AW-1:0]] = in_data;
        end
        wp_d = push ? wp_q + (AW+1)'(1) : wp_q;
        rp_d = pop ? rp_q + (AW+1)'(1) : rp_q;
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            wp_q <= '0;
            rp_q <= '0;
        end else begin
            wp_q <= wp_d;
            rp_q <= rp_d;
        end
        mem_q <= mem_d;
    end
endmodule

// >>> hw/ssba_deser.sv
// Deserializer with bypass, DDR capture and one-bit slip
`timescale 1ns/1ns
module ssba_deser (
    input  wire logic                 mclk,
    input  wire logic                 rst_n,
    input  wire logic                 bit_in,
    input  wire ssba_pkg::ssba_jsel_t jsel,
    input  wire logic                 slip,
    output ssba_pkg::ssba_word_t      word
);
    import ssba_pkg::*;
    logic [3:0]        cnt_q, cnt_d, jw;
    logic [WORD_W-1:0] sh_q, sh_d, mask;
    logic              ddr_hi_q, ddr_hi_d;
    ssba_word_t        word_q, word_d;

    always_comb begin
        jw       = ssba_jwidth(jsel);
        mask     = WORD_W'((11'h001 << jw) - 11'h001);
        sh_d     = {sh_q[WORD_W-2:0], bit_in};
        cnt_d    = cnt_q;
        ddr_hi_d = ddr_hi_q;
        word_d   = '{valid: 1'b0, data: word_q.data};
        if (slip) begin
            // [R13] stall one bit
            cnt_d    = cnt_q;
            // Keeps the DDR pair contiguous across a slip
            ddr_hi_d = bit_in;
        end else if (cnt_q >= jw - 4'h1) begin
            // [R15] word per J bits
            cnt_d        = 4'h0;
            word_d.valid = 1'b1;
            unique case (jsel)
                // [R3] single bit bypass
                JSEL_1:  word_d.data = {9'h000, bit_in};
                // [R4] DDR register pair
                JSEL_2:  word_d.data = {8'h00, ddr_hi_q, bit_in};
                default: word_d.data = sh_d & mask;
            endcase
        end else begin
            cnt_d = cnt_q + 4'h1;
            if (cnt_q == 4'h0) begin
                ddr_hi_d = bit_in;
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            cnt_q    <= 4'h0;
            sh_q     <= '0;
            ddr_hi_q <= 1'b0;
            word_q   <= '0;
        end else begin
            cnt_q    <= cnt_d;
            sh_q     <= sh_d;
            ddr_hi_q <= ddr_hi_d;
            word_q   <= word_d;
        end
    end

    assign word = word_q;

    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_n);

    sequence s_slip_at_end;
        slip && cnt_q == jw - 4'h1 && jsel != JSEL_1;
    endsequence
    a_slip_one_bit: assert property ( // [R16]
        s_slip_at_end ##1 (!slip && $stable(jsel)) |-> !word.valid ##1 word.valid)
        else $error("slip did not delay the word by exactly one bit");
    a_bypass_bit: assert property ( // [R3]
        (jsel == JSEL_1 && !slip) |=> word.valid && word.data == {9'h000, $past(bit_in)})
        else $error("single bit bypass lost the pin bit");
    a_ddr_pair: assert property ( // [R4]
        (jsel == JSEL_2 && $stable(jsel) && !slip && cnt_q == 4'h1)
        |=> word.valid && word.data[1:0] == {$past(bit_in, 2), $past(bit_in)})
        else $error("DDR pair captured wrongly");
    a_word_spacing: assert property ( // [R15]
        (cnt_q == jw - 4'h1 && !slip && $stable(jsel)) |=> word.valid)
        else $error("word not presented at end of J bits");
endmodule

// >>> hw/ssba_top.sv
// Top of the source-synchronous serdes with bit-slip word alignment
//
// Overview of operation
// [R1] PLL lock needs reference period of W bit clocks, W from 1 to 32.
// [R2] Word width J selectable as 4, 7, 8 or 10, apart from W.
// [R3] J of 1 passes each single bit between pin and core.
// [R4] J of 2 uses the DDR register pair of the io element.
// [R5] PLL reference chosen from pin, global or regional clock.
// [R6] Three PLL outputs: two high-speed bit clocks and one core tick. hs_clk_b runs only in FWD_FULL and is held low otherwise.
// [R7] Each channel runs at most 840 Mbps.
// [R8] At most 20 channels per PLL; larger counts are clipped.
// [R9] Cross-quadrant clocking limits low-speed channels to 462 Mbps.
// [R10] Forwarded transmit clock leaves on a data channel path.
// [R11] Full-rate forwarded clock comes straight from the bit clock.
// [R12] Divided forwarded clocks are patterned by the serializer.
// [R13] Realignment request stalls the parallel output by one bit.
// [R14] Core keeps slipping until its pattern appears, then stops.
// [R15] One word per low-speed cycle in each direction.
// [R16] Each request slips exactly one bit, seen in the next word.
//
// The register offsets and the APB interface to the registers were left to the implementer.
`timescale 1ns/1ns
module ssba_top (
    input  wire logic                    mclk,
    input  wire logic                    rst_n,
    input  wire ssba_pkg::ssba_apb_req_t apb_req,
    output ssba_pkg::ssba_apb_rsp_t      apb_rsp,
    input  wire logic                    ref_pin,
    input  wire logic                    ref_global,
    input  wire logic                    ref_regional,
    input  wire logic                    rx_ser,
    input  wire logic                    bitslip,
    output logic                         tx_ser,
    output logic                         tx_fwd_clk,
    output logic                         hs_clk_a,
    output logic                         hs_clk_b,
    output logic                         core_tick,
    output logic                         pll_locked,
    output ssba_pkg::ssba_word_t         rx_word
);
    import ssba_pkg::*;

    ssba_ctrl_t        ctrl_q, ctrl_d, wr_ctrl;
    ssba_apb_rsp_t     rsp_q, rsp_d;
    ssba_word_t        rx_w;
    logic [7:0]        slip_cnt_q, slip_cnt_d;
    logic              slip_q, slip_d;
    logic              rx_new_q, rx_new_d;
    logic [WORD_W-1:0] rx_hold_q, rx_hold_d;
    logic              clip_q, clip_d;
    logic              rate_ok_q, rate_ok_d;
    logic              ref_prev_q, ref_now, ref_rise;
    logic [4:0]        per_q, per_d;
    logic              locked_q, locked_d;
    logic [WORD_W-1:0] tx_sh_q, tx_sh_d;
    logic [3:0]        tx_cnt_q, tx_cnt_d, jw;
    logic              tick_q, tick_d;
    logic              hs_a_q, hs_a_d, hs_b_q, hs_b_d;
    logic [3:0]        fwd_cnt_q, fwd_cnt_d, fdiv;
    logic              fwd_q, fwd_d;
    logic              acc, wr_done, rd_done, stall, mapped;
    logic              tx_push, tx_in_ready, tx_out_valid, tx_pop;
    logic [WORD_W-1:0] tx_out_data;

    // Word sits left-justified so the MSB of J leaves first
    function automatic logic [WORD_W-1:0] left_align(input logic [WORD_W-1:0] w,
                                                     input logic [3:0] n);
        return WORD_W'(w << (4'hA - n));
    endfunction

    ssba_fifo #(
        .WIDTH (WORD_W),
        .DEPTH (FIFO_DEPTH)
    ) u_tx_fifo (
        .mclk      (mclk),
        .rst_n     (rst_n),
        .in_valid  (tx_push),
        .in_ready  (tx_in_ready),
        .in_data   (apb_req.pwdata[WORD_W-1:0]),
        .out_valid (tx_out_valid),
        .out_ready (tx_pop),
        .out_data  (tx_out_data)
    );

    ssba_deser u_deser (
        .mclk   (mclk),
        .rst_n  (rst_n),
        .bit_in (rx_ser),
        .jsel   (ctrl_q.jsel),
        .slip   (slip_q),
        .word   (rx_w)
    );

    // Bus side: access completes on the edge that sees pready high
    always_comb begin
        acc     = apb_req.psel && apb_req.penable;
        wr_done = acc && rsp_q.pready && apb_req.pwrite;
        rd_done = acc && rsp_q.pready && !apb_req.pwrite;
        mapped  = apb_req.paddr inside {OFS_CTRL, OFS_STATUS, OFS_TXDATA, OFS_RXDATA, OFS_SLIP};
        // Full FIFO holds the write in its access phase
        stall   = apb_req.pwrite && apb_req.paddr == OFS_TXDATA && !tx_in_ready;
        tx_push = wr_done && apb_req.paddr == OFS_TXDATA;
        rsp_d   = '0;
        if (acc && !rsp_q.pready && !stall) begin
            rsp_d.pready  = 1'b1;
            rsp_d.pslverr = !mapped;
            if (!apb_req.pwrite) begin
                unique case (apb_req.paddr)
                    OFS_CTRL:   rsp_d.prdata = 32'(ctrl_q);
                    OFS_STATUS: begin
                        rsp_d.prdata[ST_LOCKED]        = locked_q;
                        rsp_d.prdata[ST_RX_NEW]        = rx_new_q;
                        rsp_d.prdata[ST_RATE_OK]       = rate_ok_q;
                        rsp_d.prdata[ST_CHAN_CLIP]     = clip_q;
                        rsp_d.prdata[ST_TX_FULL]       = !tx_in_ready;
                        rsp_d.prdata[ST_SLIPS +: 8]    = slip_cnt_q;
                    end
                    OFS_RXDATA: begin
                        rsp_d.prdata[WORD_W-1:0] = rx_hold_q;
                        rsp_d.prdata[RX_NEW_POS] = rx_new_q;
                    end
                    default:    rsp_d.prdata = 32'h0000_0000;
                endcase
            end
        end
    end

    // Configuration and realignment requests
    always_comb begin
        ctrl_d     = ctrl_q;
        clip_d     = clip_q;
        wr_ctrl    = ssba_ctrl_t'(apb_req.pwdata[CTRL_W-1:0]);
        slip_d     = bitslip;
        slip_cnt_d = slip_cnt_q;
        if (wr_done && apb_req.paddr == OFS_CTRL) begin
            ctrl_d = wr_ctrl;
            // [R2] illegal J keeps old width
            if (wr_ctrl.jsel > JSEL_10) begin
                ctrl_d.jsel = ctrl_q.jsel;
            end
            if (wr_ctrl.ref_sel > REF_REGIONAL) begin
                ctrl_d.ref_sel = ctrl_q.ref_sel;
            end
            if (wr_ctrl.fwd_mode > FWD_DIV) begin
                ctrl_d.fwd_mode = ctrl_q.fwd_mode;
            end
            // [R8] channel count clip
            clip_d = wr_ctrl.chan_cnt > 5'(MAX_CHAN);
            if (clip_d) begin
                ctrl_d.chan_cnt = 5'(MAX_CHAN);
            end
        end
        // [R13] software slip request
        if (wr_done && apb_req.paddr == OFS_SLIP && apb_req.pwdata[0]) begin
            slip_d = 1'b1;
        end
        // [R16] one slip per request
        if (slip_q && slip_cnt_q != 8'hFF) begin
            slip_cnt_d = slip_cnt_q + 8'h01;
        end
    end

    // Receive word capture for the core and for software
    always_comb begin
        rx_hold_d = rx_hold_q;
        rx_new_d  = rx_new_q;
        if (rd_done && apb_req.paddr == OFS_RXDATA) begin
            rx_new_d = 1'b0;
        end
        // Arrival beats a clearing read in the same cycle
        if (rx_w.valid) begin
            rx_hold_d = rx_w.data;
            rx_new_d  = 1'b1;
        end
    end

    // Fast PLL model: lock when reference period equals W bit clocks
    always_comb begin
        // [R5] reference source select
        unique case (ctrl_q.ref_sel)
            REF_GLOBAL:   ref_now = ref_global;
            REF_REGIONAL: ref_now = ref_regional;
            default:      ref_now = ref_pin;
        endcase
        ref_rise = ref_now && !ref_prev_q;
        per_d    = (per_q == 5'h1F) ? per_q : per_q + 5'h01;
        locked_d = locked_q;
        // [R1] multiply check
        if (ctrl_q.mult_m1 == 5'h00) begin
            locked_d = 1'b1;
        end else if (ref_rise) begin
            per_d    = 5'h00;
            locked_d = per_q == ctrl_q.mult_m1;
        end else if (per_q > ctrl_q.mult_m1) begin
            locked_d = 1'b0;
        end
        // [R7] channel rate ceiling
        rate_ok_d = BIT_MBPS <= HS_LIMIT_MBPS;
        // [R9] cross-quadrant low-speed ceiling
        if (ctrl_q.cross_quad && ctrl_q.low_speed) begin
            rate_ok_d = BIT_MBPS <= LS_LIMIT_MBPS;
        end
    end

    // Serializer, core tick and forwarded clock
    always_comb begin
        jw       = ssba_jwidth(ctrl_q.jsel);
        fdiv     = ssba_fwd_divisor(ctrl_q.fwd_div);
        tx_pop   = 1'b0;
        tick_d   = 1'b0;
        tx_cnt_d = tx_cnt_q + 4'h1;
        tx_sh_d  = {tx_sh_q[WORD_W-2:0], 1'b0};
        // [R15] one word per low-speed cycle
        if (tx_cnt_q >= jw - 4'h1) begin
            tx_cnt_d = 4'h0;
            tick_d   = 1'b1;
            tx_pop   = tx_out_valid;
            // Empty FIFO sends zeros rather than stale data
            // [R3] J of 1 loads one bit per cycle
            tx_sh_d  = tx_out_valid ? left_align(tx_out_data, jw) : '0;
        end
        // [R6] two bit clocks; hs_clk_b toggles only in FWD_FULL and is held low otherwise
        hs_a_d    = !hs_a_q;
        hs_b_d    = (ctrl_q.fwd_mode == FWD_FULL) ? !hs_b_q : 1'b0;
        fwd_cnt_d = (fwd_cnt_q >= fdiv - 4'h1) ? 4'h0 : fwd_cnt_q + 4'h1;
        unique case (ctrl_q.fwd_mode)
            // [R11] bit clock to the pin
            FWD_FULL: fwd_d = hs_b_d;
            // [R12] divided clock pattern
            FWD_DIV:  fwd_d = fwd_cnt_d < (fdiv >> 1);
            default:  fwd_d = 1'b0;
        endcase
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            ctrl_q     <= ssba_ctrl_t'(CTRL_RST);
            rsp_q      <= '0;
            clip_q     <= 1'b0;
            slip_q     <= 1'b0;
            slip_cnt_q <= 8'h00;
            rx_hold_q  <= '0;
            rx_new_q   <= 1'b0;
            ref_prev_q <= 1'b0;
            per_q      <= 5'h00;
            locked_q   <= 1'b0;
            rate_ok_q  <= 1'b0;
            tx_sh_q    <= '0;
            tx_cnt_q   <= 4'h0;
            tick_q     <= 1'b0;
            hs_a_q     <= 1'b0;
            hs_b_q     <= 1'b0;
            fwd_cnt_q  <= 4'h0;
            fwd_q      <= 1'b0;
        end else begin
            ctrl_q     <= ctrl_d;
            rsp_q      <= rsp_d;
            clip_q     <= clip_d;
            slip_q     <= slip_d;
            slip_cnt_q <= slip_cnt_d;
            rx_hold_q  <= rx_hold_d;
            rx_new_q   <= rx_new_d;
            ref_prev_q <= ref_now;
            per_q      <= per_d;
            locked_q   <= locked_d;
            rate_ok_q  <= rate_ok_d;
            tx_sh_q    <= tx_sh_d;
            tx_cnt_q   <= tx_cnt_d;
            tick_q     <= tick_d;
            hs_a_q     <= hs_a_d;
            hs_b_q     <= hs_b_d;
            fwd_cnt_q  <= fwd_cnt_d;
            fwd_q      <= fwd_d;
        end
    end

    assign apb_rsp    = rsp_q;
    assign tx_ser     = tx_sh_q[WORD_W-1];
    // [R10] forwarded clock on a data channel
    assign tx_fwd_clk = fwd_q;
    assign hs_clk_a   = hs_a_q;
    assign hs_clk_b   = hs_b_q;
    assign core_tick  = tick_q;
    assign pll_locked = locked_q;
    assign rx_word    = rx_w;

    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_n);

    sequence s_ctrl_steady;
        $stable(ctrl_q) [*2];
    endsequence
    a_lock_period: assert property ( // [R1]
        (ref_rise && ctrl_q.mult_m1 != 5'h00 && per_q == ctrl_q.mult_m1) |=> locked_q)
        else $error("PLL did not lock on a period of W");
    a_width_legal: assert property ( // [R2]
        ctrl_q.jsel <= JSEL_10)
        else $error("illegal word width held");
    a_chan_limit: assert property ( // [R8]
        wr_done && apb_req.paddr == OFS_CTRL && wr_ctrl.chan_cnt > 5'd20
        |=> ctrl_q.chan_cnt == 5'd20 && clip_q)
        else $error("channel count not clipped to 20");
    a_full_rate_clk: assert property ( // [R11]
        (ctrl_q.fwd_mode == FWD_FULL && $stable(ctrl_q.fwd_mode)) |=> tx_fwd_clk != $past(tx_fwd_clk))
        else $error("full-rate forwarded clock did not toggle");
    a_div_clock: assert property ( // [R12]
        s_ctrl_steady ##0 (ctrl_q.fwd_mode == FWD_DIV && fwd_cnt_q == fdiv - 4'h1)
        ##1 $stable(ctrl_q) |-> tx_fwd_clk ##1 (tx_fwd_clk == ($past(fdiv) > 4'h2)))
        else $error("divided forwarded clock pattern wrong");
    a_tick_rate: assert property ( // [R15]
        s_ctrl_steady ##0 (core_tick && jw > 4'h1) |-> tx_cnt_q == 4'h0 ##1 !core_tick)
        else $error("core tick spacing not J");
    a_slip_count: assert property ( // [R16]
        (slip_q && slip_cnt_q < 8'hFF) |=> slip_cnt_q == $past(slip_cnt_q) + 8'h01)
        else $error("slip not counted once");
    a_apb_stall: assert property (
        (acc && apb_req.pwrite && apb_req.paddr == OFS_TXDATA && !tx_in_ready) |=> !rsp_q.pready)
        else $error("write accepted into a full FIFO");
endmodule

// >>> tb/ssba_peer.sv
// Peer transmitter model: repeating training word and reference clock
`timescale 1ns/1ns
module ssba_peer (
    input  wire logic       mclk,
    input  wire logic       rst_n,
    input  wire logic [3:0] jw,
    input  wire logic [9:0] pat,
    input  wire logic [5:0] wper,
    output logic            ser,
    output logic            ref_clk
);
    logic [3:0] idx_q;
    logic [5:0] rc_q;
    // word repeats so an alignment exists
    always @(posedge mclk) begin
        if (!rst_n || idx_q == 4'h0 || idx_q >= jw)
            idx_q <= jw - 4'h1;
        else
            idx_q <= idx_q - 4'h1;
        rc_q <= (!rst_n || rc_q + 6'h1 >= wper) ? 6'h0 : rc_q + 6'h1;
    end
    // earliest bit is the word MSB
    assign ser = pat[idx_q];
    // one reference rise per W bits
    assign ref_clk = (rc_q == 6'h0);
endmodule

// >>> tb/source_sync_serdes_byte_align_bench.sv
// Self-checking bench of the serdes word aligner
`timescale 1ns/1ns
module source_sync_serdes_byte_align_bench;
    import ssba_pkg::*;
    logic          mclk, rst_n, bitslip, pref, er, rx_ser;
    logic          tx_ser, tx_fwd_clk, hs_clk_a, hs_clk_b, core_tick, pll_locked;
    logic [1:0]    refsrc;
    logic [3:0]    jw;
    logic [9:0]    pat, d;
    logic [7:0]    sh;
    logic [31:0]   rd;
    int            err_count, checks, cyc, tot, a, b, c, e, k;
    ssba_apb_req_t req;
    ssba_apb_rsp_t rsp;
    ssba_word_t    rx_word;
    logic [3:0]    wid [6] = '{4'h1, 4'h2, 4'h4, 4'h7, 4'h8, 4'hA};

    ssba_top dut_u (.mclk(mclk), .rst_n(rst_n), .apb_req(req), .apb_rsp(rsp),
        .ref_pin(pref & (refsrc == 2'h0)), .ref_global(pref & (refsrc == 2'h1)),
        .ref_regional(pref & (refsrc == 2'h2)), .rx_ser(rx_ser), .bitslip(bitslip),
        .tx_ser(tx_ser), .tx_fwd_clk(tx_fwd_clk), .hs_clk_a(hs_clk_a),
        .hs_clk_b(hs_clk_b), .core_tick(core_tick), .pll_locked(pll_locked),
        .rx_word(rx_word));
    ssba_peer peer_u (.mclk(mclk), .rst_n(rst_n), .jw(jw), .pat(pat), .wper(6'h02),
        .ser(rx_ser), .ref_clk(pref));

    // W fixed at 2; cl sets cross-quadrant and low-speed together
    function automatic logic [31:0] cw(logic [2:0] j, logic [1:0] rs, logic [1:0] fw,
                                       logic [3:0] dv, logic cl, logic [4:0] ch);
        return {9'h000, ch, cl, cl, dv, fw, rs, 5'h01, j};
    endfunction

    task automatic chk(string n, logic [31:0] e, logic [31:0] g);
        checks++;
        if (g !== e) begin
            err_count++;
            $display("MISMATCH %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic apb(logic w, logic [7:0] ad, logic [31:0] wd);
        @(posedge mclk);
        req <= '{1'b1, 1'b0, w, ad, wd};
        @(posedge mclk);
        req.penable <= 1'b1;
        do begin
            @(posedge mclk);
        end while (rsp.pready !== 1'b1);
        rd = rsp.prdata;
        er = rsp.pslverr;
        req <= '0;
    endtask

    task automatic getw();
        do begin
            @(posedge mclk);
        end while (rx_word.valid !== 1'b1);
        d = rx_word.data;
    endtask

    task automatic slip();
        @(posedge mclk);
        bitslip <= 1'b1;
        @(posedge mclk);
        bitslip <= 1'b0;
        tot++;
    endtask

    task automatic tog();
        logic f, x, y;
        repeat (3) @(posedge mclk);
        a = 0;
        b = 0;
        c = 0;
        e = 0;
        repeat (8) begin
            e += int'(core_tick === 1'b1);
            f = tx_fwd_clk;
            x = hs_clk_b;
            y = hs_clk_a;
            @(posedge mclk);
            a += int'(tx_fwd_clk !== f);
            b += int'(hs_clk_b !== x);
            c += int'(hs_clk_a !== y);
        end
    endtask

    task automatic tally_and_finish();
        $display("checks %0d err_count %0d", checks, err_count);
        if (err_count == 0 && checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end

    // Whole run needs about a thousand cycles
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 20000) begin
            err_count++;
            tally_and_finish();
        end
    end

    initial begin
        rst_n = 1'b0;
        bitslip = 1'b0;
        req = '0;
        refsrc = 2'h0;
        jw = 4'h8;
        pat = 10'h080;
        sh = 8'h00;
        repeat (20) @(posedge mclk);
        rst_n <= 1'b1;
        apb(1'b0, OFS_CTRL, 32'h0);
        chk("ctrl_rst", cw(3'h4, 2'h0, 2'h0, 4'h2, 1'b0, 5'h01), rd);
        for (k = 0; k < 3; k++) begin
            apb(1'b1, OFS_CTRL, cw(3'h4, k[1:0], 2'h0, 4'h2, 1'b0, 5'h01));
            refsrc <= k[1:0];
            repeat (20) @(posedge mclk);
            chk("locked", 32'h1, {31'h0, pll_locked});
        end
        refsrc <= 2'h0;
        repeat (20) @(posedge mclk);
        chk("unlocked", 32'h0, {31'h0, pll_locked});
        refsrc <= 2'h2;
        apb(1'b1, OFS_CTRL, cw(3'h4, 2'h2, 2'h0, 4'h2, 1'b1, 5'h19));
        apb(1'b0, OFS_CTRL, 32'h0);
        chk("chan_cnt", cw(3'h4, 2'h2, 2'h0, 4'h2, 1'b1, 5'h14), rd);
        apb(1'b0, OFS_STATUS, 32'h0);
        chk("clip_rate", 32'h3, {30'h0, rd[3:2]});
        apb(1'b0, 8'h14, 32'h0);
        chk("slverr", 32'h1, {31'h0, er});
        chk("unmapped", 32'h0, rd);
        apb(1'b1, OFS_CTRL, cw(3'h4, 2'h2, 2'h1, 4'h2, 1'b0, 5'h01));
        tog();
        chk("fwd_full", 32'h8, a);
        chk("hs_pin", 32'h8, b);
        chk("hs_bit", 32'h8, c);
        chk("core_tick", 32'h1, e);
        apb(1'b1, OFS_CTRL, cw(3'h4, 2'h2, 2'h2, 4'h4, 1'b0, 5'h01));
        tog();
        chk("fwd_div4", 32'h4, a);
        chk("hs_pin_off", 32'h0, b);
        for (int i = 0; i < 6; i++) begin
            apb(1'b1, OFS_CTRL, cw(i[2:0], 2'h2, 2'h0, 4'h2, 1'b0, 5'h01));
            jw <= wid[i];
            pat <= 10'h001 << (wid[i] - 4'h1);
            repeat (4) getw();
            for (k = 0; k < 12 && d !== pat; k++) begin
                slip();
                getw();
                getw();
            end
            chk("aligned", pat, d);
            getw();
            chk("kept", pat, d);
        end
        apb(1'b0, OFS_STATUS, 32'h0);
        chk("slip_count", tot, rd[15:8]);
        apb(1'b1, OFS_CTRL, cw(3'h4, 2'h2, 2'h0, 4'h2, 1'b0, 5'h01));
        apb(1'b1, OFS_TXDATA, 32'hC3);
        for (k = 0; k < 60 && sh !== 8'hC3; k++) begin
            @(posedge mclk);
            sh = {sh[6:0], tx_ser};
        end
        chk("tx_word", 32'hC3, sh);
        // Slow drain so the eighth push must stall
        apb(1'b1, OFS_CTRL, cw(3'h5, 2'h2, 2'h0, 4'h2, 1'b0, 5'h01));
        repeat (8) apb(1'b1, OFS_TXDATA, 32'h155);
        apb(1'b0, OFS_STATUS, 32'h0);
        chk("tx_full", 32'h1, rd[4]);
        repeat (80) @(posedge mclk);
        apb(1'b0, OFS_STATUS, 32'h0);
        chk("tx_drained", 32'h0, rd[4]);
        tally_and_finish();
    end
endmodule
